// ==== design/nvmc_pkg.sv ====
package nvmc_pkg;

	////////////////////////////////////////////////////////////////
	// register byte offsets on the plain register port
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] ADDR_MASK = 4'h8;

	////////////////////////////////////////////////////////////////
	// nvm_control_one field positions
	localparam int BIT_UNUSED = 7;
	localparam int BIT_CFG    = 6;
	localparam int BIT_LATCH  = 5;
	localparam int BIT_ERASE  = 4;
	localparam int BIT_ERR    = 3;
	localparam int BIT_WRITE_ENABLE_GATE   = 2;
	localparam int BIT_WR     = 1;
	localparam int BIT_RD     = 0;

	// values after reset
	localparam logic       CTRL_BIT_RESET = 1'b0;
	localparam logic [2:0] STAT_RESET     = 3'h0;
	localparam logic [2:0] MASK_RESET     = 3'h0;

	////////////////////////////////////////////////////////////////
	// event bits, shared by status and mask
	localparam int EVT_W     = 3;
	localparam int EVT_WDONE = 0;
	localparam int EVT_RDONE = 1;
	localparam int EVT_ERR   = 2;

	// data widths
	localparam int WORD_W = 14;
	localparam int EE_W   = 8;

	////////////////////////////////////////////////////////////////
	// operation handed to the array
	typedef enum logic [1:0] {
		OP_LATCH       = 2'b00,
		OP_FLASH_WRITE = 2'b01,
		OP_FLASH_ERASE = 2'b10,
		OP_EEPROM      = 2'b11
	} nvmc_op_e;

	// write sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LATCH = 2'b01,
		ST_WAIT  = 2'b10
	} nvmc_state_e;

endpackage

// ==== design/nvmc_evt_if.sv ====
`timescale 1ns/1ps
interface nvmc_evt_if;
	logic [nvmc_pkg::EVT_W-1:0] evt;
	logic                       statWr;
	logic                       maskWr;
	logic [nvmc_pkg::EVT_W-1:0] wdata;
	logic [nvmc_pkg::EVT_W-1:0] status;
	logic [nvmc_pkg::EVT_W-1:0] mask;

	modport ctrl (output evt, statWr, maskWr, wdata, input status, mask);
	modport irq (input evt, statWr, maskWr, wdata, output status, mask);
endinterface

// ==== design/nvmc_sync.sv ====
`timescale 1ns/1ps
module nvmc_sync (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// level from the self-timer domain
	input  wire logic asyncIn,
	output logic      syncOut
);
	logic stage1_reg;

	// two stages; only the second stage is read outside
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stage1_reg <= 1'b0;
			syncOut    <= 1'b0;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end
endmodule

// ==== design/nvmc_irq.sv ====
`timescale 1ns/1ps
module nvmc_irq (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// events and register access
	nvmc_evt_if.irq   bus,
	// level interrupt
	output logic      irq
);
	logic [nvmc_pkg::EVT_W-1:0] status_reg;
	logic [nvmc_pkg::EVT_W-1:0] mask_reg;

	assign bus.status = status_reg;
	assign bus.mask   = mask_reg;

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			status_reg <= nvmc_pkg::STAT_RESET;
		end else if (bus.statWr) begin
			status_reg <= (status_reg & ~bus.wdata) | bus.evt;
		end else begin
			status_reg <= status_reg | bus.evt;
		end
	end

	// mask register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mask_reg <= nvmc_pkg::MASK_RESET;
		end else if (bus.maskWr) begin
			mask_reg <= bus.wdata;
		end
	end

	// registered output, one cycle behind status
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_reg & mask_reg);
		end
	end
endmodule

// ==== design/nvmc_ctrl.sv ====
// Overview of operation
// - bit 7 reads zero, writes to it are dropped.
// - space select one targets EEPROM/config/IDs, zero targets program flash.
// - latch only with erase clear just loads the word latch, no array cycle.
// - latch only clear commits latches; erase select overrides latch only.
// - erase select on flash erases the whole 32-word row to ones.
// - error flag set on reset-cut write, broken unlock, or protected write start.
// - write enable gate clear blocks every program and erase cycle.
// - write start on EEPROM begins erase+program; reads one until done.
// - write start ignored when address is neither EEPROM nor flash.
// - read start fetches the word within one cycle, then self-clears.
// - read start is set-only by software, cleared only by hardware.
// - error flag content is not guaranteed while a write runs.
// - error flag cleared only by software, software may also set it; here every reset clears it too.
// - write start accepted only after the unlock sequence.
// - writes self-timed; write start clears on completion, zero writes ignored.
// - EEPROM read loads only the low byte of the data pair.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module nvmc_ctrl (
	// clock and reset
	input  wire logic                           clk_sys,
	input  wire logic                           rst,
	// register port
	input  wire logic [3:0]                     regAddr,
	input  wire logic [31:0]                    regWdata,
	input  wire logic                           regWrite,
	input  wire logic                           regRead,
	output logic      [31:0]                    regRdata,
	// address decode of nvm_address_pair
	input  wire logic                           addrIsEeprom,
	input  wire logic                           addrIsFlash,
	input  wire logic                           addrProtected,
	// unlock sequence detector
	input  wire logic                           unlockArmed,
	input  wire logic                           unlockAborted,
	output logic                                unlockConsume,
	// retained flag: a write was cut by reset
	input  wire logic                           writeInterrupted,
	// array and self-timer
	input  wire logic                           arrayDoneAsync,
	input  wire logic [nvmc_pkg::WORD_W-1:0]    arrayRdata,
	output logic                                opStart,
	output logic      [1:0]                     opCode,
	output logic                                configSpaceSelect,
	// nvm_data_pair load
	output logic                                dataLoad,
	output logic                                dataLoadHigh,
	output logic      [nvmc_pkg::WORD_W-1:0]    dataWord,
	// interrupt
	output logic                                irq
);

	////////////////////////////////////////////////////////////////
	// declarations

	nvmc_evt_if evtBus ();

	nvmc_pkg::nvmc_state_e state_reg;
	nvmc_pkg::nvmc_op_e    opSel;

	logic       cfg_reg;
	logic       latch_reg;
	logic       erase_reg;
	logic       write_enable_gate_reg;
	logic       err_reg;
	logic       rd_reg;
	logic       firstCycle_reg;
	logic       doneSeen_reg;
	logic       doneSync;
	logic       doneRise;
	logic       ctrlWr;
	logic       wrAttempt;
	logic       wrAccept;
	logic       protErr;
	logic       resetCatch;
	logic       hwErrSet;
	logic       rdSet;
	logic       wrBit;
	logic       opDone;
	logic [7:0] ctrlView;

	////////////////////////////////////////////////////////////////
	// helpers

	// operation chosen by the space and mode bits
	function automatic nvmc_pkg::nvmc_op_e opDecode(
		input logic ee,
		input logic erase,
		input logic latch
	);
		if (ee) begin
			opDecode = nvmc_pkg::OP_EEPROM;
		end else if (erase) begin
			opDecode = nvmc_pkg::OP_FLASH_ERASE;
		end else if (latch) begin
			opDecode = nvmc_pkg::OP_LATCH;
		end else begin
			opDecode = nvmc_pkg::OP_FLASH_WRITE;
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// completion from the self-timer, which runs on its own oscillator

	nvmc_sync doneSyncer (
		.clk_sys (clk_sys),
		.rst     (rst),
		.asyncIn (arrayDoneAsync),
		.syncOut (doneSync)
	);

	// edge detect after the synchroniser
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			doneSeen_reg <= 1'b0;
		end else begin
			doneSeen_reg <= doneSync;
		end
	end

	assign doneRise = doneSync & ~doneSeen_reg;

	////////////////////////////////////////////////////////////////
	// write request qualification

	assign ctrlWr    = regWrite && (regAddr == nvmc_pkg::ADDR_CTRL);
	assign wrBit     = (state_reg != nvmc_pkg::ST_IDLE);

	// a one written to write start while idle; zero writes do nothing
	assign wrAttempt = ctrlWr && regWdata[nvmc_pkg::BIT_WR] && !wrBit;

	// protected target flags an error even without a start
	assign protErr   = wrAttempt && addrProtected
		&& (addrIsEeprom || addrIsFlash);

	// every gate must be open for a cycle to start
	assign wrAccept  = wrAttempt
		&& unlockArmed
		&& write_enable_gate_reg
		&& (addrIsEeprom || addrIsFlash)
		&& !addrProtected;

	assign opSel = opDecode(addrIsEeprom, erase_reg, latch_reg);

	////////////////////////////////////////////////////////////////
	// mode bits; cleared by every reset

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_reg   <= nvmc_pkg::CTRL_BIT_RESET;
			latch_reg <= nvmc_pkg::CTRL_BIT_RESET;
			erase_reg <= nvmc_pkg::CTRL_BIT_RESET;
			write_enable_gate_reg  <= nvmc_pkg::CTRL_BIT_RESET;
		end else if (ctrlWr) begin
			cfg_reg   <= regWdata[nvmc_pkg::BIT_CFG];
			latch_reg <= regWdata[nvmc_pkg::BIT_LATCH];
			erase_reg <= regWdata[nvmc_pkg::BIT_ERASE];
			write_enable_gate_reg  <= regWdata[nvmc_pkg::BIT_WRITE_ENABLE_GATE];
		end
	end

	// space select goes straight out to the address decoder
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			configSpaceSelect <= nvmc_pkg::CTRL_BIT_RESET;
		end else if (ctrlWr) begin
			configSpaceSelect <= regWdata[nvmc_pkg::BIT_CFG];
		end
	end

	////////////////////////////////////////////////////////////////
	// error flag

	// reset cannot load a port, so the retained flag is caught after release
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			firstCycle_reg <= 1'b1;
		end else begin
			firstCycle_reg <= 1'b0;
		end
	end

	assign resetCatch = firstCycle_reg && writeInterrupted;
	assign hwErrSet   = resetCatch || unlockAborted || protErr;

	// hardware only sets; software clears or sets for tests; set wins
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			err_reg <= nvmc_pkg::CTRL_BIT_RESET;
		end else if (ctrlWr) begin
			err_reg <= regWdata[nvmc_pkg::BIT_ERR] | hwErrSet;
		end else if (hwErrSet) begin
			err_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// write sequencer; write start reads one outside idle

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= nvmc_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				nvmc_pkg::ST_IDLE: begin
					if (wrAccept && opSel == nvmc_pkg::OP_LATCH) begin
						state_reg <= nvmc_pkg::ST_LATCH;
					end else if (wrAccept) begin
						state_reg <= nvmc_pkg::ST_WAIT;
					end
				end
				nvmc_pkg::ST_LATCH: begin
					state_reg <= nvmc_pkg::ST_IDLE;
				end
				nvmc_pkg::ST_WAIT: begin
					if (doneRise) begin
						state_reg <= nvmc_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= nvmc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign opDone = (state_reg == nvmc_pkg::ST_LATCH)
		|| (state_reg == nvmc_pkg::ST_WAIT && doneRise);

	// one-cycle start toward the array with the chosen operation
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			opStart <= 1'b0;
			opCode  <= nvmc_pkg::OP_LATCH;
		end else begin
			opStart <= wrAccept;
			if (wrAccept) begin
				opCode <= opSel;
			end
		end
	end

	// any attempt uses up the unlock, so a retry needs a fresh sequence
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			unlockConsume <= 1'b0;
		end else begin
			unlockConsume <= wrAttempt;
		end
	end

	////////////////////////////////////////////////////////////////
	// read start: set by software, held for one cycle only

	assign rdSet = ctrlWr && regWdata[nvmc_pkg::BIT_RD];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_reg <= nvmc_pkg::CTRL_BIT_RESET;
		end else begin
			rd_reg <= rdSet;
		end
	end

	// word is taken from the array while read start is high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dataLoad     <= 1'b0;
			dataLoadHigh <= 1'b0;
			dataWord     <= '0;
		end else begin
			dataLoad     <= rd_reg;
			dataLoadHigh <= rd_reg && !addrIsEeprom;
			if (rd_reg && addrIsEeprom) begin
				dataWord <= {{(nvmc_pkg::WORD_W-nvmc_pkg::EE_W){1'b0}},
					arrayRdata[nvmc_pkg::EE_W-1:0]};
			end else if (rd_reg) begin
				dataWord <= arrayRdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt events and register traffic

	assign evtBus.evt[nvmc_pkg::EVT_WDONE] = opDone;
	assign evtBus.evt[nvmc_pkg::EVT_RDONE] = rd_reg;
	assign evtBus.evt[nvmc_pkg::EVT_ERR]   = hwErrSet;
	assign evtBus.statWr = regWrite && (regAddr == nvmc_pkg::ADDR_STAT);
	assign evtBus.maskWr = regWrite && (regAddr == nvmc_pkg::ADDR_MASK);
	assign evtBus.wdata  = regWdata[nvmc_pkg::EVT_W-1:0];

	nvmc_irq irqUnit (
		.clk_sys (clk_sys),
		.rst     (rst),
		.bus     (evtBus.irq),
		.irq     (irq)
	);

	////////////////////////////////////////////////////////////////
	// read back

	// error flag is shown as stored even mid-write; undefined there anyway
	always_comb begin
		ctrlView                      = 8'h00;
		ctrlView[nvmc_pkg::BIT_UNUSED] = 1'b0;
		ctrlView[nvmc_pkg::BIT_CFG]    = cfg_reg;
		ctrlView[nvmc_pkg::BIT_LATCH]  = latch_reg;
		ctrlView[nvmc_pkg::BIT_ERASE]  = erase_reg;
		ctrlView[nvmc_pkg::BIT_ERR]    = err_reg;
		ctrlView[nvmc_pkg::BIT_WRITE_ENABLE_GATE]   = write_enable_gate_reg;
		ctrlView[nvmc_pkg::BIT_WR]     = wrBit;
		ctrlView[nvmc_pkg::BIT_RD]     = rd_reg;
	end

	// data stand for the one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			regRdata <= 32'h0000_0000;
		end else if (regRead) begin
			case (regAddr)
				nvmc_pkg::ADDR_CTRL: begin
					regRdata <= {24'h00_0000, ctrlView};
				end
				nvmc_pkg::ADDR_STAT: begin
					regRdata <= {29'h0000_0000, evtBus.status};
				end
				nvmc_pkg::ADDR_MASK: begin
					regRdata <= {29'h0000_0000, evtBus.mask};
				end
				default: begin
					regRdata <= 32'h0000_0000;
				end
			endcase
		end else begin
			regRdata <= 32'h0000_0000;
		end
	end

endmodule

// ==== tb/nvmc_array_model.sv ====
`timescale 1ns/1ps
module nvmc_array_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// operation from the controller
	input  wire logic       opStart,
	input  wire logic [1:0] opCode,
	input  wire logic [4:0] doneDelay,
	// self-timer answer, a level whose rise ends the cycle
	output logic            arrayDoneAsync
);
	logic [4:0] cntReg;
	logic       busyReg;

	////////////////////////////////////////////////////////////////
	// self-timer: a latch load never waits on it, so only array cycles start it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cntReg         <= 5'h00;
			busyReg        <= 1'b0;
			arrayDoneAsync <= 1'b0;
		end else if (opStart && opCode != nvmc_pkg::OP_LATCH) begin
			cntReg         <= doneDelay;
			busyReg        <= 1'b1;
			arrayDoneAsync <= 1'b0;
		end else if (busyReg && cntReg == 5'h00) begin
			busyReg        <= 1'b0;
			arrayDoneAsync <= 1'b1;
		end else if (busyReg) begin
			cntReg <= cntReg - 5'h01;
		end
	end
endmodule

// ==== tb/nvmc_ctrl_assertions.sv ====
`timescale 1ns/1ps
module nvmc_ctrl_checker (
	// clock and reset
	input wire logic                        clk_sys,
	input wire logic                        rst,
	// register port
	input wire logic [3:0]                  regAddr,
	input wire logic [31:0]                 regWdata,
	input wire logic                        regWrite,
	input wire logic                        regRead,
	input wire logic [31:0]                 regRdata,
	// decode and unlock
	input wire logic                        addrIsEeprom,
	input wire logic                        addrIsFlash,
	input wire logic                        addrProtected,
	input wire logic                        unlockArmed,
	input wire logic                        unlockConsume,
	// array side
	input wire logic [nvmc_pkg::WORD_W-1:0] arrayRdata,
	input wire logic                        opStart,
	input wire logic [1:0]                  opCode,
	input wire logic                        configSpaceSelect,
	input wire logic                        dataLoad,
	input wire logic                        dataLoadHigh,
	input wire logic [nvmc_pkg::WORD_W-1:0] dataWord
);
	logic wrenReg;
	logic eraseReg;
	logic latchReg;
	logic ctrlWr;

	////////////////////////////////////////////////////////////////
	// gate and mode bits as stored before a starting write; the op is chosen from these
	assign ctrlWr = regWrite && regAddr == nvmc_pkg::ADDR_CTRL;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wrenReg  <= 1'b0;
			eraseReg <= 1'b0;
			latchReg <= 1'b0;
		end else if (ctrlWr) begin
			wrenReg  <= regWdata[nvmc_pkg::BIT_WRITE_ENABLE_GATE];
			eraseReg <= regWdata[nvmc_pkg::BIT_ERASE];
			latchReg <= regWdata[nvmc_pkg::BIT_LATCH];
		end
	end

	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////
	bit7_zero_a: assert property (regRead && regAddr == nvmc_pkg::ADDR_CTRL |=> regRdata[7] == 1'b0)
		else $error("control bit 7 read back as one");
	space_copy_a: assert property (ctrlWr |=> configSpaceSelect == $past(regWdata[nvmc_pkg::BIT_CFG]))
		else $error("space select does not follow the written bit");
	start_gate_a: assert property (opStart |-> $past(ctrlWr && regWdata[nvmc_pkg::BIT_WR] && wrenReg
		&& unlockArmed && (addrIsEeprom || addrIsFlash) && !addrProtected))
		else $error("operation started without a legal start write");
	op_kind_a: assert property (opStart |-> opCode == ($past(addrIsEeprom) ? nvmc_pkg::OP_EEPROM :
		$past(eraseReg) ? nvmc_pkg::OP_FLASH_ERASE :
		$past(latchReg) ? nvmc_pkg::OP_LATCH : nvmc_pkg::OP_FLASH_WRITE))
		else $error("operation code does not match the mode bits");
	consume_tie_a: assert property (opStart |-> unlockConsume)
		else $error("accepted start did not consume the unlock");
	start_pulse_a: assert property (opStart |=> !opStart)
		else $error("start pulse longer than one cycle");
	read_load_a: assert property (!$past(ctrlWr) && ctrlWr && regWdata[nvmc_pkg::BIT_RD] ##1 !ctrlWr
		|=> dataLoad && dataLoadHigh == !$past(addrIsEeprom)
		&& dataWord == ($past(addrIsEeprom) ? {6'h0, $past(arrayRdata[7:0])} : $past(arrayRdata)))
		else $error("read did not load the expected word in time");
	reset_clear_a: assert property ($fell(rst) |-> !configSpaceSelect && !opStart && !dataLoad)
		else $error("outputs not cleared by reset");

	// main scenarios
	cover property (opStart && opCode == nvmc_pkg::OP_FLASH_ERASE);
	cover property (opStart && opCode == nvmc_pkg::OP_EEPROM);
	cover property (dataLoad && !dataLoadHigh);
	cover property (opStart && opCode == nvmc_pkg::OP_LATCH);
endmodule

bind nvmc_ctrl nvmc_ctrl_checker chk (
	.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
	.regRead(regRead), .regRdata(regRdata), .addrIsEeprom(addrIsEeprom), .addrIsFlash(addrIsFlash),
	.addrProtected(addrProtected), .unlockArmed(unlockArmed), .unlockConsume(unlockConsume),
	.arrayRdata(arrayRdata), .opStart(opStart), .opCode(opCode), .configSpaceSelect(configSpaceSelect),
	.dataLoad(dataLoad), .dataLoadHigh(dataLoadHigh), .dataWord(dataWord)
);

// ==== tb/nvm_control_register_logic_tb.sv ====
`timescale 1ns/1ps
module nvm_control_register_logic_tb;
	logic        clk_sys, rst, regWrite, regRead, addrIsEeprom, addrIsFlash, addrProtected;
	logic        unlockArmed, unlockAborted, unlockConsume, writeInterrupted, arrayDoneAsync;
	logic        opStart, configSpaceSelect, dataLoad, dataLoadHigh, irq, ee, lt, er;
	logic [1:0]  opCode;
	logic [3:0]  regAddr;
	logic [4:0]  doneDelay;
	logic [13:0] arrayRdata, dataWord;
	logic [31:0] regWdata, regRdata, rv;
	int          errorCnt, cmpCount, seed, n;

	nvmc_ctrl dut (
		.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .addrIsEeprom(addrIsEeprom), .addrIsFlash(addrIsFlash),
		.addrProtected(addrProtected), .unlockArmed(unlockArmed), .unlockAborted(unlockAborted),
		.unlockConsume(unlockConsume), .writeInterrupted(writeInterrupted), .arrayDoneAsync(arrayDoneAsync),
		.arrayRdata(arrayRdata), .opStart(opStart), .opCode(opCode), .configSpaceSelect(configSpaceSelect),
		.dataLoad(dataLoad), .dataLoadHigh(dataLoadHigh), .dataWord(dataWord), .irq(irq)
	);

	nvmc_array_model array (
		.clk_sys(clk_sys), .rst(rst), .opStart(opStart), .opCode(opCode), .doneDelay(doneDelay),
		.arrayDoneAsync(arrayDoneAsync)
	);

	// 40 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmpCount++;
		if (seen !== exp) begin
			errorCnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic completeRun();
		if (errorCnt == 0 && cmpCount > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// strobes drop after their edge; the next call waits an edge, so no double drive
	task automatic regWr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask

	task automatic regChk(input logic [3:0] a, input logic [31:0] exp, input string what);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		rv = regRdata;
		if (what != "") check(rv, exp, what);
	endtask

	function automatic logic [1:0] expOp(input logic e, input logic erase, input logic latch);
		if (e) return nvmc_pkg::OP_EEPROM;
		if (erase) return nvmc_pkg::OP_FLASH_ERASE;
		return latch ? nvmc_pkg::OP_LATCH : nvmc_pkg::OP_FLASH_WRITE;
	endfunction

	////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h0B46;
		errorCnt = 0;
		cmpCount = 0;
		{rst, writeInterrupted, addrIsFlash, unlockArmed} = 4'hF;
		{regWrite, regRead, addrIsEeprom, addrProtected, unlockAborted} = 5'h00;
		regAddr = 4'h0;
		regWdata = 32'h0;
		arrayRdata = 14'h0;
		doneDelay = 5'h08;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		writeInterrupted <= 1'b0;
		// write cut by reset leaves the error flag up, all else cleared
		regChk(nvmc_pkg::ADDR_CTRL, 32'h08, "ctrl after reset");
		regChk(nvmc_pkg::ADDR_STAT, 32'h4, "status after reset");
		regChk(4'hC, 32'h0, "unmapped read");
		regWr(nvmc_pkg::ADDR_CTRL, 32'h0);
		regChk(nvmc_pkg::ADDR_CTRL, 32'h0, "error cleared");
		regWr(nvmc_pkg::ADDR_CTRL, 32'h88);
		regChk(nvmc_pkg::ADDR_CTRL, 32'h08, "error set by software");
		regWr(nvmc_pkg::ADDR_CTRL, 32'h0);
		// random reads from both spaces; EEPROM fills only the low byte
		for (int i = 0; i < 6; i++) begin
			ee = (i == 0) ? 1'b1 : 1'($random(seed));
			addrIsEeprom <= ee;
			addrIsFlash  <= !ee;
			arrayRdata   <= 14'($random(seed));
			regWr(nvmc_pkg::ADDR_CTRL, {25'h0, ee, 6'h01});
			@(posedge clk_sys);
			#1;
			check(dataLoad, 1'b1, "data load");
			check(dataLoadHigh, !ee, "high load");
			check(dataWord, ee ? {6'h0, arrayRdata[7:0]} : arrayRdata, "read word");
			regChk(nvmc_pkg::ADDR_CTRL, {25'h0, ee, 6'h00}, "read start cleared");
		end
		regChk(nvmc_pkg::ADDR_STAT, 32'h6, "read done status");
		regWr(nvmc_pkg::ADDR_STAT, 32'h7);
		// every operation kind; erase select overrides latch only
		for (int k = 0; k < 4; k++) begin
			{ee, er, lt} = {k == 0, k == 1, k == 1 || k == 2};
			addrIsEeprom <= ee;
			addrIsFlash  <= !ee;
			doneDelay    <= 5'(8 + ($random(seed) & 15));
			regWr(nvmc_pkg::ADDR_CTRL, {25'h0, ee, lt, er, 4'h4});
			regWr(nvmc_pkg::ADDR_CTRL, {25'h0, ee, lt, er, 4'h6});
			#1;
			check(opStart, 1'b1, "op start");
			check(opCode, expOp(ee, er, lt), "op code");
			check(unlockConsume, 1'b1, "unlock consumed");
			if (expOp(ee, er, lt) != nvmc_pkg::OP_LATCH) begin
				regWr(nvmc_pkg::ADDR_CTRL, {25'h0, ee, lt, er, 4'h4});
				regChk(nvmc_pkg::ADDR_CTRL, 32'h0, "");
				check(rv[nvmc_pkg::BIT_WR], 1'b1, "write busy");
			end
			for (n = 0; n < 40; n++) begin
				regChk(nvmc_pkg::ADDR_CTRL, 32'h0, "");
				if (rv[nvmc_pkg::BIT_WR] === 1'b0) break;
			end
			if (n == 40) begin
				errorCnt++;
				completeRun();
			end
			check(rv, {25'h0, ee, lt, er, 4'h4}, "ctrl after op");
		end
		regChk(nvmc_pkg::ADDR_STAT, 32'h1, "write done");
		// refused starts: gate off, no unlock, no target, protected target
		for (int j = 0; j < 4; j++) begin
			{addrIsEeprom, addrIsFlash, addrProtected, unlockArmed} <= {1'b0, j != 2, j == 3, j != 1};
			regWr(nvmc_pkg::ADDR_CTRL, (j == 0) ? 32'h00 : 32'h04);
			regWr(nvmc_pkg::ADDR_CTRL, (j == 0) ? 32'h02 : 32'h06);
			#1;
			check(opStart, 1'b0, "refused start");
			regChk(nvmc_pkg::ADDR_CTRL, (j == 3) ? 32'h0C : (j == 0) ? 32'h0 : 32'h04, "refused ctrl");
			regWr(nvmc_pkg::ADDR_CTRL, 32'h0);
		end
		// broken unlock raises the error event, then mask and clear the interrupt
		regWr(nvmc_pkg::ADDR_STAT, 32'h7);
		regWr(nvmc_pkg::ADDR_MASK, 32'h4);
		@(posedge clk_sys);
		unlockAborted <= 1'b1;
		@(posedge clk_sys);
		unlockAborted <= 1'b0;
		regChk(nvmc_pkg::ADDR_CTRL, 32'h08, "abort error");
		check(irq, 1'b1, "irq raised");
		regWr(nvmc_pkg::ADDR_MASK, 32'h0);
		@(posedge clk_sys);
		#1;
		check(irq, 1'b0, "irq masked");
		regWr(nvmc_pkg::ADDR_MASK, 32'h4);
		regWr(nvmc_pkg::ADDR_STAT, 32'h4);
		@(posedge clk_sys);
		#1;
		check(irq, 1'b0, "irq cleared");
		// second reset mid-run with no cut write
		regWr(nvmc_pkg::ADDR_CTRL, 32'h74);
		#1;
		check(configSpaceSelect, 1'b1, "space select");
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		regChk(nvmc_pkg::ADDR_CTRL, 32'h0, "ctrl after second reset");
		completeRun();
	end
endmodule
